// *** host_port_pkg.sv ***
/*
  Constants, state codes and carrier types for the host message port.
  Assumes a single 200 MHz system clock and a host-owned serial link clock.
*/
// What this block does
// - Device acknowledges an address byte matching its configured 7-bit address.
// - Current-address pointer advances after each read byte, except at 0xFF.
// - Read pointer starts at 0xFF after reset.
// - Stream register returns next outgoing byte, or 0xFF when none waits.
// - Registers are read-only; writes carry incoming message bytes or set the pointer.
// - Message writes carry two or more bytes; single byte only sets pointer.
// - Four-wire slave shares pins and is active only with strap at 0.
// - Four-wire side is slave only; never drives clock or select.
// - Four-wire side has no addressing; it streams outgoing bytes only.
// - Incoming parsing stops after 50 consecutive 0xFF, resumes on other byte.
// - With nothing to send the device shifts out 0xFF.
// - Each byte in is matched by one byte out in the same transfer.
// - Register 0xFD/0xFE give byte count, 0xFF gives the stream.
// - Registers 0x00 to 0xFC are reserved and read as 0x00.
// - Slave address item holds 7-bit address in its upper bits.
package host_port_pkg;

  localparam logic [7:0] REG_STREAM     = 8'hFF;
  localparam logic [7:0] REG_COUNT_HI   = 8'hFD;
  localparam logic [7:0] REG_COUNT_LO   = 8'hFE;
  localparam logic [7:0] PTR_RESET      = 8'hFF;
  localparam logic [7:0] FILLER_BYTE    = 8'hFF;
  localparam logic [7:0] RESERVED_VALUE = 8'h00;
  localparam logic [1:0] MIN_MSG_WRITE  = 2'h2;
  localparam logic [2:0] LAST_BIT       = 3'h7;
  localparam logic       STRAP_SPI      = 1'b0;
  localparam int         FF_SUSPEND     = 50;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_beat_s;

  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_ADDR     = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_RX       = 7'h08,
    ST_RX_ACK   = 7'h10,
    ST_TX       = 7'h20,
    ST_TX_ACK   = 7'h40
  } i2c_state_e;

endpackage

// *** spi_link_slave.sv ***
/*
  Four-wire serial slave on the host's link clock, mode 0, MSB first.
  Assumes select low frames whole bytes and the clock idles low.
*/
`timescale 1ns/10ps
module spi_link_slave
  import host_port_pkg::*;
(
  input  wire logic       spi_clk,
  input  wire logic       reset,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  input  wire logic       stage_req,
  input  wire logic [7:0] stage_data,
  output logic            stage_ack,
  output logic            rx_toggle,
  output logic [7:0]      rx_data,
  output logic            miso_o
);
  import host_port_pkg::*;

  logic       rst_s1_reg;
  logic       rst_s2_reg;
  logic       req_s1_reg;
  logic       req_s2_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] in_shift_reg;
  logic [7:0] out_shift_reg;

  // ---------------------------------------------------------------
  // Crossings into the link domain
  // ---------------------------------------------------------------
  always_ff @(posedge spi_clk) begin
    rst_s1_reg <= reset;
    rst_s2_reg <= rst_s1_reg;
    req_s1_reg <= stage_req;
    req_s2_reg <= req_s1_reg;
  end

  // ---------------------------------------------------------------
  // Receive on rising edge
  // ---------------------------------------------------------------
  always_ff @(posedge spi_clk) begin
    if (rst_s2_reg) begin
      bit_cnt_reg  <= '0;
      in_shift_reg <= '0;
      rx_data      <= '0;
      rx_toggle    <= 1'b0;
    end else if (!cs_n) begin
      in_shift_reg <= {in_shift_reg[6:0], mosi};
      bit_cnt_reg  <= bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == LAST_BIT) begin
        rx_data   <= {in_shift_reg[6:0], mosi};
        rx_toggle <= ~rx_toggle;
      end
    end
  end

  // ---------------------------------------------------------------
  // Transmit on falling edge, next byte loaded at each byte boundary
  // ---------------------------------------------------------------
  always_ff @(negedge spi_clk) begin
    if (rst_s2_reg) begin
      out_shift_reg <= FILLER_BYTE;
      stage_ack     <= 1'b0;
    end else if (!cs_n) begin
      if (bit_cnt_reg == 3'h0) begin
        if (req_s2_reg != stage_ack) begin
          out_shift_reg <= stage_data;
          stage_ack     <= ~stage_ack;
        end else begin
          out_shift_reg <= FILLER_BYTE;
        end
      end else begin
        out_shift_reg <= {out_shift_reg[6:0], 1'b1};
      end
    end
  end

  assign miso_o = out_shift_reg[7];

  a_idle_filler: assert property (@(negedge spi_clk) disable iff (rst_s2_reg)
    (!cs_n && bit_cnt_reg == 3'h0 && req_s2_reg == stage_ack) |=> out_shift_reg == FILLER_BYTE)
    else $error("filler not loaded when nothing staged");

  a_byte_pairing: assert property (@(posedge spi_clk) disable iff (rst_s2_reg)
    (!cs_n && bit_cnt_reg == LAST_BIT) |=> rx_toggle != $past(rx_toggle))
    else $error("received byte not handed over at byte end");

endmodule // spi_link_slave

// *** host_message_port.sv ***
/*
  Host message port: two-wire slave with register pointer, or four-wire
  slave stream, chosen by the interface-select strap after reset.
  Assumes a message source with byte count and a parser sink on clk.
*/
`timescale 1ns/10ps
module host_message_port
  import host_port_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    spi_clk,
  input  wire logic                    strap_sel,
  input  wire logic [7:0]              own_addr_cfg,
  input  wire logic                    scl_i,
  input  wire logic                    sda_i,
  output logic                         sda_o,
  output logic                         sda_oe,
  input  wire logic                    cs_n,
  input  wire logic                    mosi,
  output logic                         miso_o,
  output logic                         miso_oe,
  input  wire logic                    out_valid,
  input  wire logic [7:0]              out_data,
  output logic                         out_ready,
  input  wire logic [15:0]             avail_count,
  output host_port_pkg::byte_beat_s    msg_in,
  output logic                         spi_mode,
  output logic                         parse_suspended
);
  import host_port_pkg::*;

  logic       scl_s1_reg, scl_s2_reg, scl_s3_reg;
  logic       sda_s1_reg, sda_s2_reg, sda_s3_reg;
  logic       strap_s1_reg, strap_s2_reg;
  logic       strap_taken_reg;
  logic       spi_mode_reg;
  i2c_state_e state_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic       done_reg;
  logic       rw_reg;
  logic       nack_reg;
  logic       drive_reg;
  logic [7:0] tx_shift_reg;
  logic [7:0] ptr_reg;
  logic       wr_open_reg;
  logic [1:0] wcount_reg;
  logic [7:0] held_reg;
  logic       stage_req_reg;
  logic [7:0] stage_data_reg;
  logic       ack_s1_reg, ack_s2_reg;
  logic       rx_s1_reg, rx_s2_reg, rx_s3_reg;
  logic [5:0] ff_cnt_reg;
  byte_beat_s msg_in_reg;

  logic       i2c_en, scl_rise, scl_fall, start_det, stop_det;
  logic       addr_hit, tx_load, i2c_pop, spi_pop, byte_in, write_end;
  logic       rx_evt, spi_ack, rx_toggle;
  logic [7:0] read_value, rx_byte;
  byte_beat_s i2c_beat, spi_beat;

  // ---------------------------------------------------------------
  // Pin synchronisers and strap capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    scl_s1_reg   <= scl_i;
    scl_s2_reg   <= scl_s1_reg;
    scl_s3_reg   <= scl_s2_reg;
    sda_s1_reg   <= sda_i;
    sda_s2_reg   <= sda_s1_reg;
    sda_s3_reg   <= sda_s2_reg;
    strap_s1_reg <= strap_sel;
    strap_s2_reg <= strap_s1_reg;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      strap_taken_reg <= 1'b0;
      spi_mode_reg    <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      spi_mode_reg    <= (strap_s2_reg == STRAP_SPI);
    end
  end

  assign spi_mode  = spi_mode_reg;
  assign i2c_en    = strap_taken_reg && !spi_mode_reg;
  assign scl_rise  = scl_s2_reg && !scl_s3_reg;
  assign scl_fall  = !scl_s2_reg && scl_s3_reg;
  assign start_det = i2c_en && scl_s2_reg && scl_s3_reg && !sda_s2_reg && sda_s3_reg;
  assign stop_det  = i2c_en && scl_s2_reg && scl_s3_reg && sda_s2_reg && !sda_s3_reg;
  assign addr_hit  = shift_reg[7:1] == own_addr_cfg[7:1];

  // ---------------------------------------------------------------
  // Register read view
  // ---------------------------------------------------------------
  always_comb begin
    if (ptr_reg == REG_STREAM) begin
      read_value = out_valid ? out_data : FILLER_BYTE;
    end else if (ptr_reg == REG_COUNT_HI) begin
      read_value = avail_count[15:8];
    end else if (ptr_reg == REG_COUNT_LO) begin
      read_value = avail_count[7:0];
    end else begin
      read_value = RESERVED_VALUE;
    end
  end

  assign tx_load   = i2c_en && scl_fall &&
                     ((state_reg == ST_ADDR && done_reg && addr_hit && shift_reg[0]) ||
                      (state_reg == ST_TX_ACK && !nack_reg));
  assign i2c_pop   = tx_load && ptr_reg == REG_STREAM && out_valid;
  assign byte_in   = i2c_en && scl_fall && state_reg == ST_RX && done_reg;
  assign write_end = (start_det || stop_det) && wr_open_reg;

  // ---------------------------------------------------------------
  // Two-wire slave sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset || !i2c_en) begin
      state_reg   <= ST_IDLE;
      shift_reg   <= '0;
      bit_cnt_reg <= '0;
      done_reg    <= 1'b0;
      rw_reg      <= 1'b0;
      nack_reg    <= 1'b0;
      drive_reg   <= 1'b0;
    end else if (start_det) begin
      state_reg   <= ST_ADDR;
      bit_cnt_reg <= '0;
      done_reg    <= 1'b0;
      drive_reg   <= 1'b0;
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
      drive_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_s2_reg};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            done_reg    <= bit_cnt_reg == LAST_BIT;
          end else if (scl_fall && done_reg) begin
            done_reg <= 1'b0;
            if (state_reg == ST_RX) begin
              state_reg <= ST_RX_ACK;
              drive_reg <= 1'b1;
            end else if (addr_hit) begin
              state_reg <= ST_ADDR_ACK;
              drive_reg <= 1'b1;
              rw_reg    <= shift_reg[0];
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= '0;
            state_reg   <= rw_reg ? ST_TX : ST_RX;
            drive_reg   <= rw_reg && !tx_shift_reg[7];
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            state_reg <= ST_RX;
            drive_reg <= 1'b0;
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            done_reg    <= bit_cnt_reg == LAST_BIT;
          end else if (scl_fall) begin
            if (done_reg) begin
              done_reg  <= 1'b0;
              state_reg <= ST_TX_ACK;
              drive_reg <= 1'b0;
            end else begin
              drive_reg <= !tx_shift_reg[6];
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            nack_reg <= sda_s2_reg;
          end else if (scl_fall) begin
            bit_cnt_reg <= '0;
            state_reg   <= nack_reg ? ST_IDLE : ST_TX;
            drive_reg   <= !nack_reg && !read_value[7];
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          drive_reg <= 1'b0;
        end
      endcase
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = drive_reg;

  // ---------------------------------------------------------------
  // Read data shifter and register pointer
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_shift_reg <= FILLER_BYTE;
    end else if (tx_load) begin
      tx_shift_reg <= read_value;
    end else if (state_reg == ST_TX && scl_fall && !done_reg) begin
      tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ptr_reg <= PTR_RESET;
    end else if (write_end && wcount_reg == 2'h1) begin
      ptr_reg <= held_reg;
    end else if (tx_load && ptr_reg != REG_STREAM) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Write path: last byte held back until the length is known
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset || !i2c_en) begin
      wr_open_reg <= 1'b0;
      wcount_reg  <= '0;
      held_reg    <= '0;
    end else if (write_end) begin
      wr_open_reg <= 1'b0;
      wcount_reg  <= '0;
    end else if (state_reg == ST_ADDR_ACK && scl_fall && !rw_reg) begin
      wr_open_reg <= 1'b1;
      wcount_reg  <= '0;
    end else if (byte_in) begin
      held_reg <= shift_reg;
      if (wcount_reg != MIN_MSG_WRITE) begin
        wcount_reg <= wcount_reg + 2'h1;
      end
    end
  end

  assign i2c_beat.valid = (byte_in && wcount_reg != 2'h0) ||
                          (write_end && wcount_reg == MIN_MSG_WRITE);
  assign i2c_beat.data  = held_reg;

  // ---------------------------------------------------------------
  // Four-wire stream staging and receive crossing
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    ack_s1_reg <= spi_ack;
    ack_s2_reg <= ack_s1_reg;
    rx_s1_reg  <= rx_toggle;
    rx_s2_reg  <= rx_s1_reg;
    rx_s3_reg  <= rx_s2_reg;
  end

  assign spi_pop   = spi_mode_reg && strap_taken_reg && stage_req_reg == ack_s2_reg && out_valid;
  assign out_ready = i2c_pop || spi_pop;

  always_ff @(posedge clk) begin
    if (reset) begin
      stage_req_reg  <= 1'b0;
      stage_data_reg <= FILLER_BYTE;
    end else if (spi_pop) begin
      stage_req_reg  <= ~stage_req_reg;
      stage_data_reg <= out_data;
    end
  end

  spi_link_slave u_link (
    .spi_clk    (spi_clk),
    .reset      (reset),
    .cs_n       (cs_n),
    .mosi       (mosi),
    .stage_req  (stage_req_reg),
    .stage_data (stage_data_reg),
    .stage_ack  (spi_ack),
    .rx_toggle  (rx_toggle),
    .rx_data    (rx_byte),
    .miso_o     (miso_o)
  );

  assign miso_oe = spi_mode_reg && !cs_n;

  assign rx_evt = spi_mode_reg && (rx_s2_reg != rx_s3_reg);

  always_ff @(posedge clk) begin
    if (reset) begin
      ff_cnt_reg <= '0;
    end else if (rx_evt) begin
      if (rx_byte != FILLER_BYTE) begin
        ff_cnt_reg <= '0;
      end else if (ff_cnt_reg != 6'(FF_SUSPEND)) begin
        ff_cnt_reg <= ff_cnt_reg + 6'h01;
      end
    end
  end

  assign spi_beat.valid   = rx_evt && (rx_byte != FILLER_BYTE || ff_cnt_reg != 6'(FF_SUSPEND));
  assign spi_beat.data    = rx_byte;
  assign parse_suspended  = ff_cnt_reg == 6'(FF_SUSPEND);

  always_ff @(posedge clk) begin
    if (reset) begin
      msg_in_reg <= '0;
    end else begin
      msg_in_reg <= spi_mode_reg ? spi_beat : i2c_beat;
    end
  end

  assign msg_in = msg_in_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_addr_ack: assert property (@(posedge clk) disable iff (reset)
    (i2c_en && state_reg == ST_ADDR && scl_fall && done_reg && addr_hit && !start_det && !stop_det)
      |=> state_reg == ST_ADDR_ACK && sda_oe)
    else $error("matching address not acknowledged");

  a_ptr_top_hold: assert property (@(posedge clk) disable iff (reset)
    (tx_load && ptr_reg == REG_STREAM && !write_end) |=> ptr_reg == REG_STREAM)
    else $error("pointer moved off top register");

  a_ptr_advance: assert property (@(posedge clk) disable iff (reset)
    (tx_load && ptr_reg != REG_STREAM) |=> ptr_reg == $past(ptr_reg) + 8'h01)
    else $error("pointer did not advance by one");

  a_ptr_startup: assert property (@(posedge clk)
    reset |=> ptr_reg == PTR_RESET)
    else $error("pointer not at top after reset");

  a_stream_filler: assert property (@(posedge clk) disable iff (reset)
    (tx_load && ptr_reg == REG_STREAM && !out_valid) |=> tx_shift_reg == FILLER_BYTE && !$past(out_ready))
    else $error("empty stream read did not give filler");

  a_single_write: assert property (@(posedge clk) disable iff (reset)
    (write_end && wcount_reg == 2'h1) |=> ptr_reg == $past(held_reg) ##1 !msg_in.valid)
    else $error("single-byte write not taken as pointer");

  a_strap_quiet: assert property (@(posedge clk) disable iff (reset)
    (!spi_mode_reg |-> !miso_oe) and (spi_mode_reg |-> !sda_oe))
    else $error("inactive port drives its pin");

  a_parse_stop: assert property (@(posedge clk) disable iff (reset)
    (rx_evt && rx_byte == FILLER_BYTE && parse_suspended) |=> !msg_in.valid)
    else $error("filler byte passed while suspended");

  a_parse_resume: assert property (@(posedge clk) disable iff (reset)
    (rx_evt && rx_byte != FILLER_BYTE) |=> msg_in.valid && msg_in.data == $past(rx_byte) && !parse_suspended)
    else $error("parsing did not resume on data byte");

endmodule // host_message_port

// *** host_bus_model.sv ***
/*
  Host-side bus master model: two-wire master and four-wire link master.
  Assumes the bench resolves the open-drain data line and the link data line.
*/
`timescale 1ns/10ps
module host_bus_model (
  input  wire logic clk,
  input  wire logic sda_line,
  input  wire logic miso_line,
  output logic      scl,
  output logic      sda_drv,
  output logic      spi_clk,
  output logic      cs_n,
  output logic      mosi
);
  localparam int HALF = 40;

  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    spi_clk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b1;
  end

  // ----------------------------------------
  // Two-wire master
  // ----------------------------------------
  task automatic i2c_bit(input logic b, output logic s);
    repeat (10) @(posedge clk);
    sda_drv <= b;
    repeat (HALF) @(posedge clk);
    scl <= 1'b1;
    repeat (HALF) @(posedge clk);
    s = sda_line;
    scl <= 1'b0;
  endtask

  task automatic i2c_start();
    repeat (10) @(posedge clk);
    sda_drv <= 1'b1;
    repeat (HALF) @(posedge clk);
    scl <= 1'b1;
    repeat (HALF) @(posedge clk);
    sda_drv <= 1'b0;
    repeat (HALF) @(posedge clk);
    scl <= 1'b0;
  endtask

  task automatic i2c_stop();
    repeat (10) @(posedge clk);
    sda_drv <= 1'b0;
    repeat (HALF) @(posedge clk);
    scl <= 1'b1;
    repeat (HALF) @(posedge clk);
    sda_drv <= 1'b1;
    repeat (HALF) @(posedge clk);
  endtask

  task automatic i2c_wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) i2c_bit(d[i], s);
    i2c_bit(1'b1, s);
    ack = (s === 1'b0);
  endtask

  task automatic i2c_write(input logic [7:0] dev, input int n, input logic [7:0] d [4],
                           input logic stop, output logic ok);
    logic a;
    i2c_start();
    i2c_wr(dev, ok);
    for (int i = 0; i < n; i++) begin
      i2c_wr(d[i], a);
      ok = ok & a;
    end
    if (stop) i2c_stop();
  endtask

  task automatic i2c_read(input logic [7:0] dev, input int n, output logic [7:0] d [8], output logic ok);
    logic s;
    i2c_start();
    i2c_wr(dev | 8'h01, ok);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        i2c_bit(1'b1, s);
        d[k][i] = s;
      end
      i2c_bit(k == n - 1, s);
    end
    i2c_stop();
  endtask

  // ----------------------------------------
  // Four-wire link master, clock in frames and in pulses with select high
  // ----------------------------------------
  task automatic link_pulses();
    repeat (4) begin
      #3 spi_clk <= 1'b1;
      #3 spi_clk <= 1'b0;
    end
  endtask

  task automatic link_select(input logic en);
    @(posedge clk);
    cs_n <= !en;
    repeat (4) @(posedge clk);
  endtask

  task automatic link_byte(input logic [7:0] tx, output logic [7:0] rx);
    #1.7;
    for (int i = 7; i >= 0; i--) begin
      mosi <= tx[i];
      #3;
      rx[i] = miso_line;
      spi_clk <= 1'b1;
      #3;
      spi_clk <= 1'b0;
    end
    mosi <= 1'b1;
    repeat (20) @(posedge clk);
  endtask
endmodule // host_bus_model

// *** host_message_port_tb_top.sv ***
/*
  Self-checking bench for the host message port in both link modes.
  Assumes the host bus model as far side and a queue as message source.
*/
`timescale 1ns/10ps
`define CHECK(g, e) begin checked++; if ((g) !== (e)) begin failures++; $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module host_message_port_tb_top;
  import host_port_pkg::*;
  localparam logic [7:0] DEV = 8'h84;
  logic        clk, reset, spi_clk, strap_sel, scl, sda_drv, sda_o, sda_oe, cs_n, mosi;
  logic        miso_o, miso_oe, miso_last, out_valid, out_ready, spi_mode, parse_suspended;
  logic [7:0]  own_addr_cfg, out_data;
  logic [15:0] avail_count;
  byte_beat_s  msg_in;
  logic [7:0]  src_q[$];
  logic [7:0]  rx_q[$];
  int          failures = 0;
  int          checked = 0;
  wire         sda_line = sda_drv & ~(sda_oe & ~sda_o);
  wire         miso_line = miso_oe ? miso_o : ~miso_last;

  host_message_port host_message_port_i (.clk(clk), .reset(reset), .spi_clk(spi_clk),
    .strap_sel(strap_sel), .own_addr_cfg(own_addr_cfg), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe(sda_oe), .cs_n(cs_n), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready), .avail_count(avail_count), .msg_in(msg_in),
    .spi_mode(spi_mode), .parse_suspended(parse_suspended));
  host_bus_model host_bus_model_i (.clk(clk), .sda_line(sda_line), .miso_line(miso_line), .scl(scl),
    .sda_drv(sda_drv), .spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi));

  // ----------------------------------------
  // Clock, message source and sink
  // ----------------------------------------
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  always @(posedge spi_clk) if (miso_oe === 1'b1) miso_last <= miso_o;
  always @(posedge clk) begin
    if (out_ready === 1'b1 && src_q.size() > 0) void'(src_q.pop_front());
    out_valid <= (src_q.size() > 0);
    out_data <= (src_q.size() > 0) ? src_q[0] : 8'h00;
    if (msg_in.valid === 1'b1) rx_q.push_back(msg_in.data);
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic do_reset(input logic strap);
    @(posedge clk);
    reset <= 1'b1;
    strap_sel <= strap;
    host_bus_model_i.link_pulses();
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    host_bus_model_i.link_pulses();
    repeat (8) @(posedge clk);
  endtask

  task automatic t_current_read();
    logic [7:0] d [8];
    logic ok;
    src_q = '{8'h3C, 8'h5A};
    `CHECK(spi_mode, 1'b0)
    host_bus_model_i.i2c_read(DEV, 3, d, ok);
    `CHECK(ok, 1'b1)
    `CHECK(d[0], 8'h3C)
    `CHECK(d[1], 8'h5A)
    `CHECK(d[2], FILLER_BYTE)
  endtask

  task automatic t_random_read();
    logic [7:0] w [4];
    logic [7:0] d [8];
    logic [7:0] e [5];
    logic ok;
    w = '{8'hFC, 8'h00, 8'h00, 8'h00};
    e = '{RESERVED_VALUE, avail_count[15:8], avail_count[7:0], FILLER_BYTE, FILLER_BYTE};
    host_bus_model_i.i2c_write(DEV, 1, w, 1'b0, ok);
    `CHECK(ok, 1'b1)
    host_bus_model_i.i2c_read(DEV, 5, d, ok);
    for (int i = 0; i < 5; i++) `CHECK(d[i], e[i])
  endtask

  task automatic t_msg_write();
    logic [7:0] w [4];
    logic [7:0] d [8];
    logic ok;
    rx_q.delete();
    w = '{8'hB5, 8'h62, 8'h06, 8'h00};
    host_bus_model_i.i2c_write(DEV, 3, w, 1'b1, ok);
    repeat (20) @(posedge clk);
    `CHECK(ok, 1'b1)
    for (int i = 0; i < 3; i++) `CHECK(rx_q[i], w[i])
    w[0] = REG_COUNT_HI;
    host_bus_model_i.i2c_write(DEV, 1, w, 1'b1, ok);
    repeat (20) @(posedge clk);
    `CHECK(rx_q.size(), 3)
    host_bus_model_i.i2c_read(DEV, 2, d, ok);
    `CHECK(d[0], avail_count[15:8])
    `CHECK(d[1], avail_count[7:0])
    host_bus_model_i.i2c_write(8'h86, 0, w, 1'b1, ok);
    `CHECK(ok, 1'b0)
  endtask

  task automatic t_link_stream();
    logic [7:0] tx [4];
    logic [7:0] ex [4];
    logic [7:0] r;
    logic ok;
    do_reset(STRAP_SPI);
    `CHECK(spi_mode, 1'b1)
    host_bus_model_i.i2c_write(DEV, 0, tx, 1'b1, ok);
    `CHECK(ok, 1'b0)
    rx_q.delete();
    src_q = '{8'h11, 8'h22};
    tx = '{8'hB5, 8'h62, 8'h01, 8'h0A};
    ex = '{FILLER_BYTE, 8'h11, 8'h22, FILLER_BYTE};
    host_bus_model_i.link_select(1'b1);
    `CHECK(miso_oe, 1'b1)
    for (int i = 0; i < 4; i++) begin
      host_bus_model_i.link_byte(tx[i], r);
      `CHECK(r, ex[i])
    end
    host_bus_model_i.link_select(1'b0);
    `CHECK(miso_oe, 1'b0)
    for (int i = 0; i < 4; i++) `CHECK(rx_q[i], tx[i])
  endtask

  task automatic t_suspend();
    logic [7:0] r;
    rx_q.delete();
    host_bus_model_i.link_select(1'b1);
    for (int i = 1; i <= FF_SUSPEND + 1; i++) begin
      host_bus_model_i.link_byte(FILLER_BYTE, r);
      `CHECK(parse_suspended, i >= FF_SUSPEND)
      `CHECK(r, FILLER_BYTE)
    end
    host_bus_model_i.link_byte(8'h42, r);
    `CHECK(parse_suspended, 1'b0)
    host_bus_model_i.link_select(1'b0);
    `CHECK(rx_q.size(), FF_SUSPEND + 1)
    `CHECK(rx_q[FF_SUSPEND], 8'h42)
  endtask

  task automatic finish_test();
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    strap_sel = 1'b1;
    own_addr_cfg = 8'h85;
    avail_count = 16'h1234;
    out_valid = 1'b0;
    out_data = 8'h00;
    miso_last = 1'b0;
    do_reset(1'b1);
    t_current_read();
    t_random_read();
    t_msg_write();
    t_link_stream();
    t_suspend();
    finish_test();
  end

  initial begin
    #400000;
    failures++;
    finish_test();
  end
endmodule // host_message_port_tb_top
